// ---- core/ada_align.sv ----
// Automatic delay alignment: delay lines on reference and microphone,
// estimation sequencer, AXI4-Lite register slave.
// Assumes samples arrive valid/ready at 16 kHz; the estimator core
// (borrowed echo canceller) delivers i_est_done with i_est_value.
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "ada_defines.svh"
module ada_align import ada_pkg::*; #(
  parameter int DEPTH = 2400,
  parameter int SW = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // AXI4-Lite
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Sample stream: pair {mic, ref}
  input wire logic i_smp_valid,
  output logic o_smp_ready,
  input wire logic [2*SW-1:0] i_smp_data,
  output logic o_smp_valid,
  input wire logic i_smp_ready,
  output logic [2*SW-1:0] o_smp_data,
  // Reference energy detector and estimator core
  input wire logic i_ref_energetic,
  input wire logic i_est_done,
  input wire logic [12:0] i_est_value,
  output logic o_est_run,
  output logic o_canc_suspend,
  output logic o_canc_restart,
  output logic [1:0] o_adapt_cfg
);
  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [11:0] delay_reg;
  logic dir_reg;
  logic [12:0] est_reg;
  logic auto_reg, first_reg;
  logic [1:0] adapt_reg;
  logic first_done_reg, pend_reg;
  ada_state_t st_reg, st_next;
  logic [11:0] app_delay_reg;
  logic app_dir_reg;

  // Clamp keeps the correction inside the buffer length
  function automatic logic [11:0] clamp_delay(input logic [12:0] v);
    clamp_delay = (v > {1'b0, `ADA_MAX_DELAY}) ? `ADA_MAX_DELAY : v[11:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign o_awready = !aw_hold && !o_bvalid;
  assign o_wready = !w_hold && !o_bvalid;
  wire wr_go = aw_hold && w_hold && !o_bvalid;
  wire wr_known = (aw_addr == `ADA_OFS_DELAY) || (aw_addr == `ADA_OFS_DIR) ||
    (aw_addr == `ADA_OFS_CTRL) || (aw_addr == `ADA_OFS_ADAPT);
  wire wr_lo = w_strb[0];
  wire wr_hi = w_strb[1];
  // Merge written lanes onto the held length; any set bit in 15:12 of a written upper lane forces the clamp
  wire [12:0] wr_delay = {wr_hi && (w_data[15:12] != 4'h0),
    wr_hi ? w_data[11:8] : delay_reg[11:8], wr_lo ? w_data[7:0] : delay_reg[7:0]};
  wire kick = wr_go && wr_lo && (aw_addr == `ADA_OFS_CTRL) &&
    w_data[`ADA_CTRL_KICK];
  wire cfg_chg = wr_go && wr_lo && (aw_addr == `ADA_OFS_CTRL) &&
    w_data[`ADA_CTRL_CFG];
  wire est_hit = (st_reg == ADA_ESTIMATE) && i_est_done;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      o_bvalid <= 1'b0;
      o_bresp <= `ADA_RESP_OK;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_known ? `ADA_RESP_OK : `ADA_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Setting registers; in auto mode host writes to delay, direction and adaptation are ignored; an estimate wins in any mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      delay_reg <= '0;
      dir_reg <= 1'b0;
      auto_reg <= 1'b0;
      first_reg <= 1'b1;
      adapt_reg <= `ADA_ADAPT_RST;
    end else begin
      if (wr_go && (wr_lo || wr_hi) && !auto_reg && aw_addr == `ADA_OFS_DELAY) begin
        delay_reg <= clamp_delay(wr_delay);
      end
      if (wr_go && wr_lo && !auto_reg && aw_addr == `ADA_OFS_DIR) begin
        dir_reg <= w_data[0];
      end
      if (wr_go && wr_lo && aw_addr == `ADA_OFS_CTRL) begin
        auto_reg <= w_data[`ADA_CTRL_AUTO];
        first_reg <= w_data[`ADA_CTRL_FIRST];
      end
      if (wr_go && wr_lo && !auto_reg && aw_addr == `ADA_OFS_ADAPT) begin
        adapt_reg <= w_data[1:0];
      end
      if (est_hit) begin
        // Biased estimate: below bias means playback leads, delay the mic
        if (i_est_value >= `ADA_EST_BIAS) begin
          delay_reg <= clamp_delay(i_est_value - `ADA_EST_BIAS);
          dir_reg <= 1'b0;
        end else begin
          delay_reg <= clamp_delay(`ADA_EST_BIAS - i_est_value);
          dir_reg <= 1'b1;
        end
        adapt_reg <= `ADA_ADAPT_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Estimation sequencer
  wire first_req = first_reg && !first_done_reg && i_ref_energetic;
  wire want = pend_reg || first_req;
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ADA_IDLE: begin
        if (want) st_next = ADA_WAIT_REF;
      end
      ADA_WAIT_REF: begin
        if (i_ref_energetic) st_next = ADA_ESTIMATE;
      end
      ADA_ESTIMATE: begin
        if (i_est_done) st_next = ADA_RESTART;
      end
      ADA_RESTART: begin
        st_next = ADA_IDLE;
      end
      default: st_next = ADA_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= ADA_IDLE;
      pend_reg <= 1'b0;
      first_done_reg <= 1'b0;
      est_reg <= '0;
      o_est_run <= 1'b0;
      o_canc_suspend <= 1'b0;
      o_canc_restart <= 1'b0;
    end else begin
      st_reg <= st_next;
      // New requests win over the clear of the pending flag
      if (kick || (cfg_chg && auto_reg)) begin
        pend_reg <= 1'b1;
      end else if (st_reg == ADA_IDLE && st_next == ADA_WAIT_REF) begin
        pend_reg <= 1'b0;
      end
      if (first_req) first_done_reg <= 1'b1;
      if (st_reg == ADA_ESTIMATE) est_reg <= (i_est_value > `ADA_EST_MAX) ?
        `ADA_EST_MAX : i_est_value;
      o_est_run <= (st_next == ADA_ESTIMATE);
      o_canc_suspend <= (st_next == ADA_ESTIMATE);
      o_canc_restart <= (st_next == ADA_RESTART);
    end
  end
  assign o_adapt_cfg = adapt_reg;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read
  logic [31:0] rd_mux;
  always_comb begin
    case (i_araddr)
      `ADA_OFS_DELAY: rd_mux = {20'h0, delay_reg};
      `ADA_OFS_DIR: rd_mux = {31'h0, dir_reg};
      `ADA_OFS_EST: rd_mux = {19'h0, est_reg};
      `ADA_OFS_CTRL: rd_mux = {30'h0, first_reg, auto_reg};
      `ADA_OFS_STATUS: rd_mux = {31'h0, (st_reg == ADA_ESTIMATE)};
      `ADA_OFS_ADAPT: rd_mux = {30'h0, adapt_reg};
      default: rd_mux = 32'h0;
    endcase
  end
  wire rd_known = (i_araddr <= `ADA_OFS_ADAPT) && (i_araddr[1:0] == 2'b00);
  assign o_arready = !o_rvalid;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= `ADA_RESP_OK;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= rd_known ? `ADA_RESP_OK : `ADA_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Delay line: one sample pair per strobe, FIFO on the output
  logic [2*SW-1:0] line [DEPTH];
  logic [11:0] wp_reg;
  logic f_ready, f_valid_reg;
  logic [2*SW-1:0] f_data_reg;
  wire [11:0] rp = (wp_reg >= app_delay_reg) ? wp_reg - app_delay_reg :
    12'(DEPTH) + wp_reg - app_delay_reg;
  wire [SW-1:0] in_mic = i_smp_data[2*SW-1:SW];
  wire [SW-1:0] in_ref = i_smp_data[SW-1:0];
  wire [SW-1:0] old_mic = line[rp][2*SW-1:SW];
  wire [SW-1:0] old_ref = line[rp][SW-1:0];
  wire take = i_smp_valid && o_smp_ready;
  // Ready stalls whenever the FIFO stage cannot absorb
  assign o_smp_ready = !f_valid_reg || f_ready;
  always_ff @(posedge i_clk) begin
    if (take) line[wp_reg] <= i_smp_data;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_reg <= '0;
      app_delay_reg <= '0;
      app_dir_reg <= 1'b0;
      f_valid_reg <= 1'b0;
      f_data_reg <= '0;
    end else begin
      if (f_valid_reg && f_ready) f_valid_reg <= 1'b0;
      if (take) begin
        wp_reg <= (wp_reg == 12'(DEPTH - 1)) ? 12'h0 : wp_reg + 12'h1;
        f_valid_reg <= 1'b1;
        // Zero delay reads the incoming sample, not the stale slot
        f_data_reg <= (app_delay_reg == 12'h0) ? i_smp_data : app_dir_reg ?
          {old_mic, in_ref} : {in_mic, old_ref};
        // Settings latched together at the sample boundary
        app_delay_reg <= delay_reg;
        app_dir_reg <= dir_reg;
      end
    end
  end
  ada_fifo #(.WIDTH(2*SW), .DEPTH(16)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(f_valid_reg),
    .o_ready(f_ready),
    .i_data(f_data_reg),
    .o_valid(o_smp_valid),
    .i_ready(i_smp_ready),
    .o_data(o_smp_data)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_delay_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    delay_reg <= `ADA_MAX_DELAY) else $error("delay above limit");
  a_suspend_est: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg == ADA_ESTIMATE) |-> o_canc_suspend) else $error("no suspend");
  a_restart_after: assert property (@(posedge i_clk) disable iff (i_rst)
    est_hit |=> o_canc_restart ##1 !o_canc_restart) else $error("no restart");
  a_wait_energy: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg == ADA_WAIT_REF && !i_ref_energetic) |=> st_reg != ADA_ESTIMATE)
    else $error("started without energy");
  a_kick_starts: assert property (@(posedge i_clk) disable iff (i_rst)
    (kick && st_reg == ADA_IDLE) |=> ##[0:2] st_reg == ADA_WAIT_REF)
    else $error("kick ignored");
  a_boundary: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(take) |-> $stable(app_delay_reg)) else $error("mid-sample change");
  a_est_range: assert property (@(posedge i_clk) disable iff (i_rst)
    est_reg <= `ADA_EST_MAX) else $error("estimate out of range");
  a_auto_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(auto_reg) && !$past(est_hit)) |-> $stable(dir_reg))
    else $error("host wrote direction in auto");
  // Host writes in auto mode must not disturb the estimator's settings
  a_auto_delay: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_go && auto_reg && !est_hit) |=> $stable(delay_reg))
    else $error("host wrote delay in auto");
  a_auto_adapt: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_go && auto_reg && !est_hit) |=> $stable(adapt_reg))
    else $error("host wrote adaptation in auto");
  a_kick_pends: assert property (@(posedge i_clk) disable iff (i_rst)
    kick |=> pend_reg || st_reg == ADA_WAIT_REF) else $error("kick lost");
endmodule

// ---- core/ada_defines.svh ----
// Constants for the automatic delay alignment block: offsets, fields, counts.
// Assumes a 125 MHz system clock and a 16 kHz sample-strobe from the pipeline.
`ifndef ADA_DEFINES_SVH
`define ADA_DEFINES_SVH
`define ADA_OFS_DELAY 8'h00
`define ADA_OFS_DIR 8'h04
`define ADA_OFS_EST 8'h08
`define ADA_OFS_CTRL 8'h0c
`define ADA_OFS_STATUS 8'h10
`define ADA_OFS_ADAPT 8'h14
`define ADA_CTRL_AUTO 0
`define ADA_CTRL_FIRST 1
`define ADA_CTRL_KICK 2
`define ADA_CTRL_CFG 3
`define ADA_MAX_DELAY_MS 150
`define ADA_RATE_HZ 16000
`define ADA_MAX_DELAY 12'd2399
`define ADA_EST_BIAS 13'd2400
`define ADA_EST_MAX 13'd7200
`define ADA_ADAPT_RST 2'h0
`define ADA_RESP_OK 2'b00
`define ADA_RESP_SLVERR 2'b10
`endif

// ---- core/ada_fifo.sv ----
// Parameterised valid/ready FIFO for sample words.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ns
module ada_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  // Honest flags straight from the fill count
  assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_valid = (cnt_reg != '0);
  assign o_data = mem[rp_reg];
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_reg] <= i_data;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ---- core/ada_pkg.sv ----
// Types for the automatic delay alignment block.
// Assumes the defines header supplies every number other than the state encodings below.
package ada_pkg;
  typedef enum logic [1:0] {
    ADA_IDLE = 2'b00,
    ADA_WAIT_REF = 2'b01,
    ADA_ESTIMATE = 2'b10,
    ADA_RESTART = 2'b11
  } ada_state_t;
endpackage

// ---- testbench/ada_align_bench.sv ----
// Self-checking bench for the delay alignment block.
// Assumes the estimator model in its own file.
`timescale 1ns/1ns
`include "ada_defines.svh"
module ada_align_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, smp_in = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic smp_in_v = 1'h0, smp_out_r = 1'h0, energy = 1'h0;
  logic [12:0] est_val = 13'h0;
  wire logic aw_r, w_r, b_v, ar_r, r_v, s_in_r, s_out_v, ref_en, done, run, susp, restart;
  wire logic [1:0] bresp, rresp, adapt;
  wire logic [31:0] rdata, s_out;
  wire logic [12:0] est_out;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  int failures = 0;
  int n_checks = 0;
  ////////////////////////////////////////
  // Clock, 8 ns period
  always #4 clk = ~clk;
  ada_align i_dut (.i_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(aw_r), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(w_r),
    .o_bresp(bresp), .o_bvalid(b_v), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(ar_r), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(r_v),
    .i_rready(rready), .i_smp_valid(smp_in_v), .o_smp_ready(s_in_r), .i_smp_data(smp_in),
    .o_smp_valid(s_out_v), .i_smp_ready(smp_out_r), .o_smp_data(s_out),
    .i_ref_energetic(ref_en), .i_est_done(done), .i_est_value(est_out), .o_est_run(run),
    .o_canc_suspend(susp), .o_canc_restart(restart), .o_adapt_cfg(adapt));
  ada_est_model u_est (.i_clk(clk), .i_run(run), .i_energy(energy), .i_value(est_val),
    .o_energetic(ref_en), .o_done(done), .o_value(est_out));
  ////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles: handshakes judged at the negedge before the taking edge
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    repeat (100) begin
      @(negedge clk);
      ha = awvalid && aw_r;
      hw = wvalid && w_r;
      hb = b_v;
      r = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
      if (hb) bready <= 1'h0;
      if (hb) break;
    end
    chk(hb, 1);
    chk(r, er);
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    repeat (100) begin
      @(negedge clk);
      ha = arvalid && ar_r;
      hr = r_v;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'h0;
      if (hr) rready <= 1'h0;
      if (hr) break;
    end
    chk(hr, 1);
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, exp);
    chk(r, `ADA_RESP_OK);
  endtask
  // Bounded wait: 0 for the run level, 1 for the restart pulse
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(which ? restart : run) && n < 300);
    chk(n < 300, 1);
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic est_cycle(input logic [31:0] ctrl, input logic [12:0] v,
                           input logic [31:0] dly, input logic [31:0] dir);
    est_val <= v;
    if (ctrl != 0) wchk(`ADA_OFS_CTRL, ctrl, `ADA_RESP_OK);
    repeat (20) @(posedge clk);
    rchk(`ADA_OFS_STATUS, 0, 32'h1);
    energy <= 1'h1;
    wait_for(0);
    chk(susp, 1);
    rchk(`ADA_OFS_STATUS, 1, 32'h1);
    wait_for(1);
    chk(run, 0);
    energy <= 1'h0;
    rchk(`ADA_OFS_DELAY, dly, 32'hffffffff);
    rchk(`ADA_OFS_DIR, dir, 32'hffffffff);
    rchk(`ADA_OFS_EST, v, 32'hffffffff);
    rchk(`ADA_OFS_STATUS, 0, 32'h1);
  endtask
  // Sink stalls until the buffer refuses, then drains 24 samples
  task automatic stream(input logic dir, input int d);
    logic [31:0] got[$];
    logic hi, ho;
    logic [15:0] m, f;
    int k, kfull;
    k = 0;
    kfull = -1;
    wchk(`ADA_OFS_DELAY, d, `ADA_RESP_OK);
    wchk(`ADA_OFS_DIR, {31'h0, dir}, `ADA_RESP_OK);
    smp_out_r <= 1'h0;
    smp_in_v <= 1'h1;
    smp_in <= {16'h1000, 16'h2000};
    repeat (300) begin
      @(negedge clk);
      hi = smp_in_v && s_in_r;
      ho = s_out_v && smp_out_r;
      if (!s_in_r && kfull < 0) kfull = k;
      if (ho) got.push_back(s_out);
      @(posedge clk);
      if (hi) k++;
      if (hi) smp_in <= {16'h1000 + 16'(k), 16'h2000 + 16'(k)};
      if (hi && k == 24) smp_in_v <= 1'h0;
      if (kfull >= 0) smp_out_r <= 1'h1;
      if (got.size() == 24) break;
    end
    chk(kfull >= 16, 1);
    chk(got.size(), 24);
    // First sample still carries the setting latched before the writes
    for (int j = (d > 0) ? d : 1; j < got.size(); j++) begin
      m = 16'h1000 + (dir ? 16'(j - d) : 16'(j));
      f = 16'h2000 + (dir ? 16'(j) : 16'(j - d));
      chk(got[j], {m, f});
    end
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rchk(`ADA_OFS_DELAY, 0, 32'hffffffff);
    rchk(`ADA_OFS_DIR, 0, 32'hffffffff);
    rchk(`ADA_OFS_CTRL, 32'h2, 32'h3);
    chk(adapt, 0);
    est_cycle(0, 13'd2405, 5, 0);
    est_cycle(32'h4, 13'd2393, 7, 1);
    est_cycle(32'h4, 13'd0, 2399, 1);
    est_cycle(32'h4, 13'd7200, 2399, 0);
    wchk(`ADA_OFS_CTRL, 32'h1, `ADA_RESP_OK);
    rchk(`ADA_OFS_CTRL, 32'h1, 32'h1);
    wchk(`ADA_OFS_DELAY, 100, `ADA_RESP_OK);
    rchk(`ADA_OFS_DELAY, 2399, 32'hffffffff);
    wchk(`ADA_OFS_ADAPT, 2, `ADA_RESP_OK);
    chk(adapt, 0);
    est_cycle(32'h9, 13'd2400, 0, 0);
    wchk(`ADA_OFS_CTRL, 32'h0, `ADA_RESP_OK);
    wchk(`ADA_OFS_ADAPT, 2, `ADA_RESP_OK);
    chk(adapt, 2);
    wchk(8'h40, 1, `ADA_RESP_SLVERR);
    rd(8'h40, rd_d, rd_r);
    chk(rd_d, 0);
    chk(rd_r, `ADA_RESP_SLVERR);
    stream(1'h0, 3);
    stream(1'h1, 5);
    stream(1'h0, 0);
    conclude();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule

// ---- testbench/ada_est_model.sv ----
// Model of the borrowed canceller acting as delay estimator.
// Assumes the bench sets reference energy and the value to report.
`timescale 1ns/1ns
module ada_est_model #(
  parameter int LAT = 40
) (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_energy,
  input wire logic [12:0] i_value,
  output logic o_energetic,
  output logic o_done,
  output logic [12:0] o_value
);
  int cnt = 0;
  initial begin
    o_done = 1'h0;
    o_value = 13'h0;
  end
  ////////////////////////////////////////
  // Energy only while the bench plays reference
  assign o_energetic = i_energy;
  // One answer per run; value not held outside the pulse
  always @(posedge i_clk) begin
    cnt <= i_run ? cnt + 1 : 0;
    o_done <= i_run && cnt == LAT;
    o_value <= (i_run && cnt == LAT) ? i_value : ~o_value;
  end
endmodule
